// File: tbc_regs.svh
// Constants for the trigger and break controller: widths, mode codes, reset values and depths.
// Assumes inclusion by bare name from the package, checker, core model and bench files; holds definitions only.
`ifndef TBC_REGS_SVH
`define TBC_REGS_SVH

// ****************************************************************
// Trigger-mode codes (four-bit field of the trigger control word)
// ****************************************************************
`define TBC_MODE_A_ONLY      4'h0
`define TBC_MODE_A_OR_B      4'h1
`define TBC_MODE_A_THEN_B    4'h2
`define TBC_MODE_EVENT_B     4'h3
`define TBC_MODE_A_THEN_EV_B 4'h4
`define TBC_MODE_A_AND_B     4'h5
`define TBC_MODE_A_AND_NOT_B 4'h6
`define TBC_MODE_INSIDE      4'h7
`define TBC_MODE_OUTSIDE     4'h8

// ****************************************************************
// FIFO geometry and reset values
// ****************************************************************
`define TBC_FIFO_DEPTH 4'h8
`define TBC_FIFO_AW    3
`define TBC_CNT_RESET  4'h0
`define TBC_WORD_W     17
`define TBC_COF_DEC    17'h00002

`endif

// File: tbc_pkg.sv
// Types shared by the trigger and break controller and its capture memory.
// Assumes tbc_regs.svh is on the include path.
`include "tbc_regs.svh"

package tbc_pkg;

    // Control bits that software sets up before a run.
    typedef struct packed {
        logic module_enable;          // Enables arming, triggering and capture.
        logic arm_request;            // Request to arm the run.
        logic capture_after_trigger;  // Begin-type run when set.
        logic opcode_qualify_sel;     // Qualify matches with opcode tracking.
        logic break_enable;           // Allow CPU break requests.
        logic tag_break_sel;          // Tag-type break when set, force-type when clear.
        logic read_write_enable_a;    // Enables read/write selection in full modes.
        logic read_write_a;           // Read when set, write when clear.
        logic [3:0] trigger_mode;     // Trigger mode code.
    } tbc_ctrl_t;

    // Raw comparator and opcode-tracking inputs for one bus cycle.
    typedef struct packed {
        logic match_a;                // Comparator A raw match.
        logic match_b_read;           // Comparator B match against read data.
        logic match_b_write;          // Comparator B match against write data.
        logic match_b_addr;           // Comparator B match against the address bus.
        logic opcode_a;               // Opcode at A's address executed.
        logic opcode_b;               // Opcode at B's address executed.
        logic is_write;               // Current bus cycle is a write.
    } tbc_match_t;

    // Run state; Gray codes along idle, armed, capturing.
    typedef enum logic [1:0] {
        TBC_IDLE    = 2'b00,
        TBC_ARMED   = 2'b01,
        TBC_CAPTURE = 2'b11
    } tbc_state_t;

endpackage

// File: tbc_capture_mem.sv
// Eight-word capture memory that overwrites its oldest entry once full.
// Assumes one clock; write and shift requests come from the controller.
`timescale 1ns/1ps

module tbc_capture_mem
    import tbc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic clear,
    input wire logic write,
    input wire logic [`TBC_WORD_W-1:0] wdata,
    input wire logic shift,
    output logic [`TBC_WORD_W-1:0] rdata
);
    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    logic [`TBC_WORD_W-1:0] mem [0:7];  // Circular storage.
    logic [`TBC_FIFO_AW-1:0] wr_ptr;    // Next location written.
    logic [`TBC_FIFO_AW-1:0] rd_ptr;    // Oldest location.
    logic [3:0] fill;                   // Number of words held.
    wire full = (fill == `TBC_FIFO_DEPTH);
    wire drop_oldest = write && full;   // Oldest falls out when full.

    // Writes store at the write pointer; no reset needed for data.
    always_ff @(posedge CLOCK) begin
        if (write) begin
            mem[wr_ptr] <= wdata;
        end
    end

    // Pointer and fill bookkeeping.
    always_ff @(posedge CLOCK) begin
        if (SRST || clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= `TBC_CNT_RESET;
        end else begin
            if (write) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (drop_oldest || (shift && !write && fill != 4'h0)) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            if (write && !full) begin
                fill <= fill + 4'h1;
            end else if (shift && !write && fill != 4'h0) begin
                fill <= fill - 4'h1;
            end
        end
    end

    // Read data comes out of a register.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            rdata <= '0;
        end else begin
            rdata <= mem[rd_ptr];
        end
    end
endmodule

// File: tbc_trigger_break.sv
// Trigger and break controller of the in-circuit debug unit.
// Assumes comparator matches and change-of-flow indicators arrive synchronous to CLOCK from the core.
`timescale 1ns/1ps

module tbc_trigger_break
    import tbc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire tbc_ctrl_t CTRL,
    input wire logic ARM_WRITE_ZERO,
    input wire tbc_match_t MATCH,
    input wire logic [1:0] CORE_COF,
    input wire logic [`TBC_WORD_W-1:0] CORE_ADDR,
    input wire logic [7:0] CORE_DATA,
    input wire logic FIFO_SHIFT,
    output logic ARM_REQUEST,
    output logic ARMED_FLAG,
    output logic MATCH_A_FLAG,
    output logic MATCH_B_FLAG,
    output logic MATCH_C_FLAG,
    output logic [3:0] FIFO_COUNT,
    output logic [`TBC_WORD_W-1:0] FIFO_DATA,
    output logic FORCE_BREAK,
    output logic TAG_BREAK
);
    // ****************************************************************
    // Mode decode
    // ****************************************************************
    wire [3:0] mode = CTRL.trigger_mode;
    // Event-only modes skip opcode qualification and are always begin runs.
    wire event_only = (mode == `TBC_MODE_EVENT_B) || (mode == `TBC_MODE_A_THEN_EV_B);
    wire full_mode = (mode == `TBC_MODE_A_AND_B) || (mode == `TBC_MODE_A_AND_NOT_B);
    wire begin_run = CTRL.capture_after_trigger || event_only;
    wire then_mode = (mode == `TBC_MODE_A_THEN_B) || (mode == `TBC_MODE_A_THEN_EV_B);

    // ****************************************************************
    // Comparator qualification
    // ****************************************************************
    // Full modes compare B against write data only for a selected write.
    wire sel_write = CTRL.read_write_enable_a && !CTRL.read_write_a;
    wire full_b = sel_write ? (MATCH.match_b_write && MATCH.is_write)
                            : (MATCH.match_b_read && !MATCH.is_write);
    wire full_a = CTRL.read_write_enable_a ? (MATCH.match_a && (MATCH.is_write == !CTRL.read_write_a))
                                           : MATCH.match_a;
    wire raw_a = full_mode ? full_a : MATCH.match_a;
    wire raw_b_pre = full_mode ? full_b : MATCH.match_b_addr;
    wire raw_b = (mode == `TBC_MODE_A_AND_NOT_B) ? !raw_b_pre : raw_b_pre;
    // Opcode tracking gates matches unless the mode is event-only.
    wire use_opcode = CTRL.opcode_qualify_sel && !event_only;
    wire qual_a = raw_a && (!use_opcode || MATCH.opcode_a);
    wire qual_b = raw_b && (!use_opcode || MATCH.opcode_b);

    // ****************************************************************
    // Trigger-mode evaluation
    // ****************************************************************
    logic seen_a;         // A has matched in a then-mode.
    logic set_a;          // A flag set this cycle.
    logic set_b;          // B flag set this cycle.
    logic trig;           // Trigger condition met.

    // Per-mode flag and trigger decode.
    always_comb begin
        set_a = 1'b0;
        set_b = 1'b0;
        trig = 1'b0;
        unique case (mode)
            `TBC_MODE_A_ONLY: begin
                set_a = qual_a;
                trig = qual_a;
            end
            `TBC_MODE_A_OR_B: begin
                set_a = qual_a;
                set_b = qual_b;
                trig = qual_a || qual_b;
            end
            `TBC_MODE_A_THEN_B, `TBC_MODE_A_THEN_EV_B: begin
                set_a = qual_a;
                set_b = qual_b && seen_a;
                trig = qual_b && seen_a;
            end
            `TBC_MODE_EVENT_B: begin
                set_b = qual_b;
                trig = qual_b;
            end
            `TBC_MODE_A_AND_B, `TBC_MODE_A_AND_NOT_B, `TBC_MODE_INSIDE: begin
                set_a = qual_a && qual_b;
                set_b = qual_a && qual_b;
                trig = qual_a && qual_b;
            end
            `TBC_MODE_OUTSIDE: begin
                set_a = qual_a;
                set_b = qual_b;
                trig = qual_a || qual_b;
            end
            default: begin
                trig = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Run state machine
    // ****************************************************************
    tbc_state_t state;
    tbc_state_t next_state;
    wire arm_go = CTRL.module_enable && CTRL.arm_request && !ARM_REQUEST;
    wire arm_start = (state == TBC_IDLE) && CTRL.module_enable && CTRL.arm_request;
    wire armed_now = (state != TBC_IDLE);
    wire end_trigger = (state == TBC_ARMED) && !begin_run && trig;
    wire begin_trigger = (state == TBC_ARMED) && begin_run && trig;
    wire fifo_full = (FIFO_COUNT == `TBC_FIFO_DEPTH);
    wire fill_done = (state == TBC_CAPTURE) && fifo_full;
    wire run_done = end_trigger || fill_done;
    wire abort = !CTRL.module_enable || ARM_WRITE_ZERO;

    // Next run state.
    always_comb begin
        next_state = state;
        unique case (state)
            TBC_IDLE: begin
                if (arm_start) begin
                    next_state = TBC_ARMED;
                end
            end
            TBC_ARMED: begin
                if (abort || end_trigger) begin
                    next_state = TBC_IDLE;
                end else if (begin_trigger) begin
                    next_state = TBC_CAPTURE;
                end
            end
            TBC_CAPTURE: begin
                if (abort || fill_done) begin
                    next_state = TBC_IDLE;
                end
            end
            default: begin
                next_state = TBC_IDLE;
            end
        endcase
    end

    // State register; any reset ends the run in progress.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state <= TBC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Arm request follows software, cleared by completion or reset.
    always_ff @(posedge CLOCK) begin
        if (SRST || ARM_WRITE_ZERO || run_done) begin
            ARM_REQUEST <= 1'b0;
        end else if (arm_go) begin
            ARM_REQUEST <= 1'b1;
        end
    end

    // Armed flag mirrors the state and drops whenever disabled.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ARMED_FLAG <= 1'b0;
        end else begin
            ARMED_FLAG <= (next_state != TBC_IDLE) && CTRL.module_enable;
        end
    end

    // A-then tracking remembers the first A match of the run.
    always_ff @(posedge CLOCK) begin
        if (SRST || arm_start) begin
            seen_a <= 1'b0;
        end else if (then_mode && qual_a && armed_now) begin
            seen_a <= 1'b1;
        end
    end

    // ****************************************************************
    // Match flags
    // ****************************************************************
    // Arming clears all flags; matches while armed set the A and B flags.
    always_ff @(posedge CLOCK) begin
        if (SRST || arm_start) begin
            MATCH_A_FLAG <= 1'b0;
            MATCH_B_FLAG <= 1'b0;
            MATCH_C_FLAG <= 1'b0;
        end else if (state == TBC_ARMED) begin
            MATCH_A_FLAG <= MATCH_A_FLAG || set_a;
            MATCH_B_FLAG <= MATCH_B_FLAG || set_b;
        end
    end

    // ****************************************************************
    // Capture path
    // ****************************************************************
    logic [`TBC_WORD_W-1:0] prev_addr;  // Address of the previous cycle.
    // Branch source is the previous address less two.
    wire [`TBC_WORD_W-1:0] branch_src = prev_addr - `TBC_COF_DEC;
    wire cof_hit = CORE_COF[1] || CORE_COF[0];
    wire [`TBC_WORD_W-1:0] cof_word = CORE_COF[1] ? CORE_ADDR : branch_src;
    wire [`TBC_WORD_W-1:0] event_word = {9'h000, CORE_DATA};
    // End runs store up to and including the trigger cycle; begin runs after trigger.
    wire store_end = (state == TBC_ARMED) && !begin_run && cof_hit && !abort;
    wire store_begin_cof = (state == TBC_CAPTURE) && !event_only && cof_hit && !fifo_full;
    wire store_event = (state == TBC_CAPTURE) && event_only && set_b && !fifo_full;
    wire store = store_end || store_begin_cof || store_event;
    wire [`TBC_WORD_W-1:0] store_word = event_only ? event_word : cof_word;
    // Reads only shift the memory while the run is not armed.
    wire shift_ok = FIFO_SHIFT && !armed_now && CTRL.module_enable;

    // Previous address register for branch-source reconstruction.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            prev_addr <= '0;
        end else begin
            prev_addr <= CORE_ADDR;
        end
    end

    // Valid count stops at eight and clears on arming.
    always_ff @(posedge CLOCK) begin
        if (SRST || arm_start) begin
            FIFO_COUNT <= `TBC_CNT_RESET;
        end else if (store && FIFO_COUNT != `TBC_FIFO_DEPTH) begin
            FIFO_COUNT <= FIFO_COUNT + 4'h1;
        end
    end

    // Capture memory drops its oldest word when written full.
    tbc_capture_mem u_mem (
        .CLOCK(CLOCK),
        .SRST(SRST),
        .clear(arm_start),
        .write(store),
        .wdata(store_word),
        .shift(shift_ok),
        .rdata(FIFO_DATA)
    );

    // ****************************************************************
    // Break requests
    // ****************************************************************
    // Tag breaks in full end runs look at A alone.
    wire tag_src = full_mode ? qual_a : trig;
    wire end_break = (state == TBC_ARMED) && !begin_run && CTRL.break_enable;
    wire begin_break = fill_done && CTRL.break_enable;

    // Force break is a one-cycle pulse; tag break marks the queue.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            FORCE_BREAK <= 1'b0;
            TAG_BREAK <= 1'b0;
        end else begin
            FORCE_BREAK <= !CTRL.tag_break_sel && ((end_break && trig) || begin_break);
            TAG_BREAK <= CTRL.tag_break_sel && ((end_break && tag_src) || begin_break);
        end
    end
endmodule

// File: tbc_trigger_break_chk.sv
// Concurrent checks on the ports of the trigger and break controller.
// Assumes tbc_pkg and tbc_regs.svh are compiled first; bound to every controller instance.
`timescale 1ns/1ps
`include "tbc_regs.svh"
module tbc_trigger_break_chk
    import tbc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire tbc_ctrl_t CTRL,
    input wire logic ARM_WRITE_ZERO,
    input wire tbc_match_t MATCH,
    input wire logic ARM_REQUEST,
    input wire logic ARMED_FLAG,
    input wire logic MATCH_A_FLAG,
    input wire logic MATCH_B_FLAG,
    input wire logic MATCH_C_FLAG,
    input wire logic [3:0] FIFO_COUNT,
    input wire logic FORCE_BREAK
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (SRST);
    // Decodes of the run set-up; all checks but dis_low_a and wr_zero_a are built on these.
    wire arm_req = CTRL.module_enable && CTRL.arm_request;
    wire arm_go = arm_req && !ARMED_FLAG && !ARM_WRITE_ZERO;
    wire mode_a = CTRL.trigger_mode == `TBC_MODE_A_ONLY;
    wire brk_f = CTRL.break_enable && !CTRL.tag_break_sel;
    wire wr_sel = CTRL.read_write_enable_a && !CTRL.read_write_a;
    wire b_sel = wr_sel ? MATCH.match_b_write : MATCH.match_b_read;
    wire any_m = |MATCH[6:3];
    wire bgn_a = ARMED_FLAG && CTRL.capture_after_trigger && mode_a;
    wire quiet = ARMED_FLAG && !CTRL.opcode_qualify_sel && !MATCH_A_FLAG && !MATCH_B_FLAG;
    wire lone = quiet && CTRL.trigger_mode == `TBC_MODE_A_AND_B && MATCH.match_a != b_sel;
    wire tb_wait = quiet && CTRL.trigger_mode == `TBC_MODE_A_THEN_B && !MATCH.match_a;
    wire end_run = CTRL.module_enable && !CTRL.capture_after_trigger && !CTRL.opcode_qualify_sel && !ARM_WRITE_ZERO;
    // An unqualified A-only end-run trigger, then the stop and break that must follow it.
    sequence s_end_hit;
        ARMED_FLAG && end_run && mode_a && MATCH.match_a;
    endsequence
    sequence s_end_done;
        MATCH_A_FLAG && !ARMED_FLAG && !ARM_REQUEST && FORCE_BREAK == $past(brk_f);
    endsequence
    arm_sets_a: assert property (arm_go |=> ARMED_FLAG && ARM_REQUEST)
        else $error("arming missed");
    arm_clr_a: assert property (arm_go && !any_m |=> !MATCH_A_FLAG && !MATCH_B_FLAG && !MATCH_C_FLAG)
        else $error("flags kept at arming");
    dis_low_a: assert property (!CTRL.module_enable |=> !ARMED_FLAG)
        else $error("armed while disabled");
    wr_zero_a: assert property (ARM_WRITE_ZERO && !CTRL.arm_request |=> !ARMED_FLAG)
        else $error("arm write of zero ignored");
    end_hit_a: assert property (s_end_hit |=> s_end_done)
        else $error("end trigger response wrong");
    stop_store_a: assert property (!ARMED_FLAG && !arm_req |=> $stable(FIFO_COUNT))
        else $error("store while not armed");
    begin_wait_a: assert property (bgn_a && !MATCH_A_FLAG |-> FIFO_COUNT == `TBC_CNT_RESET)
        else $error("store before begin trigger");
    begin_full_a: assert property (bgn_a && FIFO_COUNT == `TBC_FIFO_DEPTH |=> !ARMED_FLAG && !ARM_REQUEST)
        else $error("still armed when full");
    lone_full_a: assert property (lone |=> !MATCH_A_FLAG && !MATCH_B_FLAG)
        else $error("lone full-mode match set a flag");
    then_b_a: assert property (tb_wait |=> !MATCH_B_FLAG)
        else $error("B taken before A");
endmodule
bind tbc_trigger_break tbc_trigger_break_chk u_chk (.CLOCK(CLOCK), .SRST(SRST), .CTRL(CTRL),
    .ARM_WRITE_ZERO(ARM_WRITE_ZERO), .MATCH(MATCH), .ARM_REQUEST(ARM_REQUEST), .ARMED_FLAG(ARMED_FLAG),
    .MATCH_A_FLAG(MATCH_A_FLAG), .MATCH_B_FLAG(MATCH_B_FLAG), .MATCH_C_FLAG(MATCH_C_FLAG),
    .FIFO_COUNT(FIFO_COUNT), .FORCE_BREAK(FORCE_BREAK));

// File: tbc_core_model.sv
// Core-side model: makes change-of-flow traffic and counts the break requests it receives.
// Assumes the controller's clock; flow is set by the bench.
`timescale 1ns/1ps
`include "tbc_regs.svh"
module tbc_core_model
    import tbc_pkg::*;
(
    input wire logic clock,
    input wire logic flow,
    input wire logic force_break,
    input wire logic tag_break,
    output logic [1:0] cof,
    output logic [`TBC_WORD_W-1:0] addr,
    output logic [7:0] data,
    output int n_force,
    output int n_tag
);
    // A taken jump every cycle while flow is high; the data bus holds a fixed byte.
    assign cof = {flow, 1'b0};
    assign data = 8'h5a;
    initial begin
        addr = '0;
        n_force = 0;
        n_tag = 0;
    end
    // The address moves on after each falling edge, away from the sampling edge.
    always @(negedge clock) begin
        addr <= addr + 17'h2;
    end
    // Every one-cycle break pulse is one request taken by the core.
    always @(posedge clock) begin
        n_force <= n_force + int'(force_break === 1'b1);
        n_tag <= n_tag + int'(tag_break === 1'b1);
    end
endmodule

// File: tbc_trigger_break_bench.sv
// Self-checking bench for the trigger and break controller.
// Assumes package, header, design, checker and core model are compiled first.
`timescale 1ns/1ps
`include "tbc_regs.svh"
module tbc_trigger_break_bench
    import tbc_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic arm_wz = 1'b0;
    logic flow = 1'b0;
    tbc_ctrl_t ctrl = '0;
    tbc_match_t match = '0;
    logic [1:0] cof;
    logic [7:0] data;
    logic [16:0] addr;
    logic [16:0] fdata;
    logic [3:0] cnt;
    logic arm_rq, armed, fa, fb, fc, fbrk, tbrk;
    int n_force, n_tag, f0;
    int err_count = 0;
    int n_checks = 0;
    // 125 MHz clock.
    always #4 clock = ~clock;
    tbc_trigger_break u_dut (.CLOCK(clock), .SRST(srst), .CTRL(ctrl), .ARM_WRITE_ZERO(arm_wz), .MATCH(match),
        .CORE_COF(cof), .CORE_ADDR(addr), .CORE_DATA(data), .FIFO_SHIFT(1'b0), .ARM_REQUEST(arm_rq),
        .ARMED_FLAG(armed), .MATCH_A_FLAG(fa), .MATCH_B_FLAG(fb), .MATCH_C_FLAG(fc), .FIFO_COUNT(cnt),
        .FIFO_DATA(fdata), .FORCE_BREAK(fbrk), .TAG_BREAK(tbrk));
    tbc_core_model u_core (.clock(clock), .flow(flow), .force_break(fbrk), .tag_break(tbrk), .cof(cof),
        .addr(addr), .data(data), .n_force(n_force), .n_tag(n_tag));
    // Inputs change only at falling edges.
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Arms a run; write selection is always on, which only full modes use.
    task automatic arm(input logic [3:0] mode, input logic bgn, input logic opq, input logic brk, input logic tag);
        ctrl = '{1'b1, 1'b1, bgn, opq, brk, tag, 1'b1, 1'b0, mode};
        cyc(1);
        ctrl.arm_request = 1'b0;
        cyc(1);
        check(17'({armed, fa, fb, fc, cnt}), 17'h80);
    endtask
    task automatic pulse(input tbc_match_t m);
        match = m;
        cyc(1);
        match = '0;
        cyc(1);
    endtask
    task automatic t_modes();
        ctrl = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0};
        cyc(2);
        check(17'(armed), 17'h0);
        for (int m = 0; m < 9; m++) begin
            arm(4'(m), 1'b0, 1'b0, 1'b0, 1'b0);
            arm_wz = (m % 2 == 0);
            ctrl.module_enable = (m % 2 == 0);
            cyc(1);
            arm_wz = 1'b0;
            cyc(1);
            check(17'(armed), 17'h0);
        end
    endtask
    task automatic t_end_force();
        f0 = n_force;
        arm(`TBC_MODE_A_ONLY, 1'b0, 1'b0, 1'b1, 1'b0);
        flow = 1'b1;
        cyc(12);
        check(17'(cnt), 17'h8);
        pulse(7'h40);
        check(17'({fa, armed, arm_rq}), 17'h4);
        cyc(4);
        flow = 1'b0;
        check(17'(cnt), 17'h8);
        check(17'(n_force - f0), 17'h1);
    endtask
    task automatic t_tag();
        f0 = n_tag;
        arm(`TBC_MODE_A_ONLY, 1'b0, 1'b1, 1'b1, 1'b1);
        pulse(7'h40);
        check(17'(fa), 17'h0);
        pulse(7'h44);
        cyc(2);
        check(17'({fa, armed}), 17'h2);
        check(17'(n_tag > f0), 17'h1);
    endtask
    task automatic t_begin();
        f0 = n_force;
        arm(`TBC_MODE_A_ONLY, 1'b1, 1'b0, 1'b1, 1'b0);
        flow = 1'b1;
        cyc(6);
        check(17'(cnt), 17'h0);
        pulse(7'h40);
        for (int i = 0; i < 20 && armed === 1'b1; i++) cyc(1);
        cyc(2);
        flow = 1'b0;
        check(17'({cnt, arm_rq}), 17'h10);
        check(17'(n_force - f0), 17'h1);
    endtask
    task automatic t_then(input logic [3:0] mode);
        arm(mode, 1'b1, 1'b0, 1'b0, 1'b0);
        pulse(7'h08);
        check(17'({fa, fb}), 17'h0);
        pulse(7'h40);
        check(17'({fa, fb}), 17'h2);
        pulse(7'h08);
        check(17'({fa, fb}), 17'h3);
        ctrl.module_enable = 1'b0;
        cyc(2);
    endtask
    task automatic t_event();
        arm(`TBC_MODE_EVENT_B, 1'b0, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 12 && armed === 1'b1; i++) pulse(7'h08);
        cyc(2);
        check(17'({fb, armed, cnt}), 17'h28);
        check(fdata, {9'h0, 8'h5a});
    endtask
    task automatic t_full();
        arm(`TBC_MODE_A_AND_B, 1'b0, 1'b0, 1'b0, 1'b0);
        pulse(7'h40);
        pulse(7'h60);
        check(17'({fa, fb}), 17'h0);
        pulse(7'h51);
        check(17'({fa, fb}), 17'h3);
    endtask
    task automatic t_or();
        arm(`TBC_MODE_A_OR_B, 1'b0, 1'b0, 1'b0, 1'b0);
        pulse(7'h48);
        check(17'({fa, fb}), 17'h3);
    endtask
    task automatic t_rst();
        arm(`TBC_MODE_A_ONLY, 1'b0, 1'b0, 1'b0, 1'b0);
        srst = 1'b1;
        cyc(1);
        srst = 1'b0;
        cyc(1);
        check(17'({armed, arm_rq}), 17'h0);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence: reset for four cycles, then every scenario in turn.
    initial begin
        cyc(4);
        srst = 1'b0;
        cyc(1);
        check(17'({arm_rq, armed, fa, fb, fc, cnt, fbrk, tbrk}), 17'h0);
        t_modes();
        t_end_force();
        t_tag();
        t_begin();
        t_then(`TBC_MODE_A_THEN_B);
        t_then(`TBC_MODE_A_THEN_EV_B);
        t_event();
        t_full();
        t_or();
        t_rst();
        summarize();
    end
    // The scenarios need well under 1000 cycles; this cuts a hang short.
    initial begin
        #100000;
        err_count++;
        summarize();
    end
endmodule
